// ### src/srs_scheduler.sv
// rate queue scheduler and control memory address generation
//
// Decided for this implementation: the strobed register port and the register addresses.
`timescale 1ns/100ps
`include "srs_defines.svh"

// Overview of operation
// - eight rate queues, two banks of four, round robin within a bank
// - eight-bit counter reloads on overflow and requests service
// - high bank requests always win over low bank requests
// - a served queue sends one cell per linked descriptor first
// - one packet per circuit under segmentation at a time
// - divider code picks counter clock of clk/4, 16, 64 or 256
// - enable bit low stops counting and servicing of a queue
// - pause honor with permit false: no requests, halt at cell end
// - pause honor clear: serve regardless of the permit input
// - low eight bits hold reload value, bits 15:12 unused
// - queue entry address is queue base joined with pointer
// - descriptor word address is base, number and word offset
// - circuit entry address is table base joined with low index bits
// - low three base bits set split from 4/16 up to 11/9 bits
// - page address hit when memory cycle address matches register
// - reg 7:0 vs address 9:2 always, 15:12 mask bits 11:8
// - high and low bank service miss status flags
module srs_scheduler (
   input  wire logic                 clk_sys_in,
   input  wire logic                 sys_rst_in,
   // register port
   input  wire logic [3:0]           reg_addr_in,
   input  wire srs_pkg::srs_word_t   reg_wdata_in,
   input  wire logic                 reg_wr_in,
   input  wire logic                 reg_rd_in,
   output srs_pkg::srs_word_t        reg_rdata_out,
   // cell interface
   input  wire logic                 transmit_permit_input_in,
   input  wire logic                 cell_done_in,
   input  wire logic                 last_desc_in,
   output logic                      cell_req_out,
   output logic                      serve_active_out,
   output logic [2:0]                serve_queue_out,
   // circuit linking
   input  wire logic                 link_req_in,
   input  wire srs_pkg::srs_word_t   link_vc_in,
   input  wire logic                 seg_done_in,
   input  wire srs_pkg::srs_word_t   seg_done_vc_in,
   output logic                      link_accept_out,
   // control memory address generation
   input  wire logic [7:0]           queue_ptr_in,
   input  wire logic [9:0]           desc_num_in,
   input  wire logic [3:0]           word_off_in,
   input  wire srs_pkg::srs_word_t   desc_vc_index_in,
   input  wire srs_pkg::srs_word_t   cong_vc_index_in,
   input  wire logic                 vc_from_cong_in,
   output srs_pkg::srs_cm_addr_t     queue_addr_out,
   output srs_pkg::srs_cm_addr_t     desc_addr_out,
   output srs_pkg::srs_cm_addr_t     vc_addr_out,
   // packet memory page match
   input  wire logic                 pm_cycle_in,
   input  wire logic [13:0]          pm_addr_in,
   output logic                      page_address_hit_out,
   // status levels
   output logic                      high_bank_service_miss_out,
   output logic                      low_bank_service_miss_out
);
   import srs_pkg::*;

   // =====================================================================
   // state
   typedef struct packed {
      srs_state_t             st;
      logic [2:0]             cur_q;
      logic [1:0]             rr_hi;
      logic [1:0]             rr_lo;
      logic [7:0]             presc;
      logic [7:0][15:0]       rq;
      srs_word_t              vc_base;
      srs_word_t              pmatch;
      srs_word_t              qbase;
      srs_word_t              dbase;
      logic                   miss_hi;
      logic                   miss_lo;
      srs_word_t              rdata;
      srs_cm_addr_t           q_addr;
      srs_cm_addr_t           d_addr;
      srs_cm_addr_t           v_addr;
      logic [7:0]             vc_valid;
      logic [7:0][15:0]       vc_id;
   } srs_sched_state_t;

   srs_sched_state_t s_q;
   srs_sched_state_t s_d;

   // =====================================================================
   // functions

   // round robin pick among four requests, starting at the pointer
   function automatic logic [2:0] srs_rr_pick(input logic [3:0] req,
                                              input logic [1:0] ptr);
      logic [2:0] res;
      logic [1:0] idx;
      res = 3'b000;
      for (int i = 3; i >= 0; i--) begin
         idx = ptr + 2'(i);
         if (req[idx]) begin
            res = {1'b1, idx};
         end
      end
      return res;
   endfunction

   // circuit table address: top base bits, then low index bits
   function automatic srs_cm_addr_t srs_vc_addr(input srs_word_t base,
                                                input srs_word_t idx);
      srs_cm_addr_t mask;
      logic [4:0]   idx_bits;
      idx_bits = 5'd16 - {2'b00, base[2:0]};
      mask     = (20'h0_0001 << idx_bits) - 20'h0_0001;
      return ({base, 4'h0} & ~mask) | ({4'h0, idx} & mask);
   endfunction

   // =====================================================================
   // rate queues

   logic [3:0] tick;
   logic [7:0] q_req;
   logic [7:0] q_miss;
   logic [7:0] q_ack;

   // shared prescaler; one free counter gives all four divide ratios
   always_comb begin
      tick[0] = &s_q.presc[1:0];
      tick[1] = &s_q.presc[3:0];
      tick[2] = &s_q.presc[5:0];
      tick[3] = &s_q.presc[7:0];
   end

   // queues 0..3 form the high bank, 4..7 the low bank
   for (genvar g = 0; g < 8; g++) begin : g_rq
      srs_rate_queue u_rq (
         .clk_sys_in (clk_sys_in),
         .sys_rst_in (sys_rst_in),
         .cfg_in     (s_q.rq[g]),
         .tick_in    (tick),
         .permit_in  (transmit_permit_input_in),
         .ack_in     (q_ack[g]),
         .req_out    (q_req[g]),
         .miss_out   (q_miss[g])
      );
   end

   // =====================================================================
   // arbitration and cell pacing

   logic [2:0]  pick_hi;
   logic [2:0]  pick_lo;
   logic        halt_now;
   logic        grant;
   srs_word_t   cur_cfg;

   assign pick_hi = srs_rr_pick(q_req[3:0], s_q.rr_hi);
   assign pick_lo = srs_rr_pick(q_req[7:4], s_q.rr_lo);
   assign cur_cfg = s_q.rq[s_q.cur_q];

   // a disabled or held-off queue stops at the next cell boundary
   assign halt_now = ~cur_cfg[`SRS_QUEUE_SERVICE_ON_BIT]
                   | (cur_cfg[`SRS_RQ_PAUSE_BIT]
                      & ~transmit_permit_input_in);

   // new grants only from idle, so a running service is never cut short
   assign grant = (s_q.st == SRS_IDLE) & (pick_hi[2] | pick_lo[2]);

   // one-cycle acknowledge to the granted queue
   always_comb begin
      q_ack = 8'h00;
      if (grant) begin
         if (pick_hi[2]) begin
            q_ack[{1'b0, pick_hi[1:0]}] = 1'b1;
         end else begin
            q_ack[{1'b1, pick_lo[1:0]}] = 1'b1;
         end
      end
   end

   // =====================================================================
   // circuit tracking

   logic       vc_hit;
   logic       vc_free;
   logic [2:0] free_slot;

   // look for the circuit among active packets and for a free slot
   always_comb begin
      vc_hit    = 1'b0;
      vc_free   = 1'b0;
      free_slot = 3'b000;
      for (int i = `SRS_VC_SLOTS - 1; i >= 0; i--) begin
         if (s_q.vc_valid[i] && s_q.vc_id[i] == link_vc_in) begin
            vc_hit = 1'b1;
         end
         if (!s_q.vc_valid[i]) begin
            vc_free   = 1'b1;
            free_slot = 3'(i);
         end
      end
   end

   // a second packet on a busy circuit waits until the first completes
   assign link_accept_out = link_req_in & ~vc_hit & vc_free;

   // =====================================================================
   // page match

   logic       pm_low_eq;
   logic [3:0] pm_high_eq;

   // address bits 1:0 are long-word byte lanes and never compared
   assign pm_low_eq = pm_addr_in[9:2] ==
                      s_q.pmatch[`SRS_PM_LOW_MSB:0];
   always_comb begin
      for (int i = 0; i < 4; i++) begin
         pm_high_eq[i] = ~s_q.pmatch[`SRS_PM_MASK_LSB + i]
                       | (pm_addr_in[10 + i]
                          == s_q.pmatch[`SRS_PM_HIGH_LSB + i]);
      end
   end

   // combinational so the memory can end the very cycle it is in
   assign page_address_hit_out = pm_cycle_in & pm_low_eq
                               & (&pm_high_eq);

   // =====================================================================
   // next state

   logic [3:0] wr_idx;
   srs_word_t  rd_word;

   assign wr_idx = reg_addr_in;

   // register reads; unmapped offsets answer zero
   always_comb begin
      rd_word = `SRS_WORD_RESET;
      if (reg_addr_in < `SRS_OFF_VC_BASE) begin
         rd_word = s_q.rq[reg_addr_in[2:0]] & `SRS_RQ_USED_MASK;
      end else begin
         case (reg_addr_in)
            `SRS_OFF_VC_BASE:    rd_word = s_q.vc_base;
            `SRS_OFF_PAGE_MATCH: rd_word = s_q.pmatch;
            `SRS_OFF_QUEUE_BASE: rd_word = s_q.qbase;
            `SRS_OFF_DESC_BASE:  rd_word = s_q.dbase;
            `SRS_OFF_STATUS: begin
               rd_word[`SRS_ST_HI_MISS_BIT] = s_q.miss_hi;
               rd_word[`SRS_ST_LO_MISS_BIT] = s_q.miss_lo;
            end
            default:             rd_word = `SRS_WORD_RESET;
         endcase
      end
   end

   // everything that changes on a clock edge
   always_comb begin
      s_d       = s_q;
      s_d.presc = s_q.presc + 8'h01;
      s_d.rdata = reg_rd_in ? rd_word : `SRS_WORD_RESET;

      // register writes
      if (reg_wr_in) begin
         if (wr_idx < `SRS_OFF_VC_BASE) begin
            s_d.rq[wr_idx[2:0]] = reg_wdata_in & `SRS_RQ_USED_MASK;
         end else begin
            case (wr_idx)
               `SRS_OFF_VC_BASE:    s_d.vc_base = reg_wdata_in;
               `SRS_OFF_PAGE_MATCH: s_d.pmatch  = reg_wdata_in;
               `SRS_OFF_QUEUE_BASE: s_d.qbase   = reg_wdata_in;
               `SRS_OFF_DESC_BASE:  s_d.dbase   = reg_wdata_in;
               `SRS_OFF_STATUS: begin
                  // write one to clear
                  if (reg_wdata_in[`SRS_ST_HI_MISS_BIT]) begin
                     s_d.miss_hi = 1'b0;
                  end
                  if (reg_wdata_in[`SRS_ST_LO_MISS_BIT]) begin
                     s_d.miss_lo = 1'b0;
                  end
               end
               default: ;
            endcase
         end
      end

      // a new miss beats a clear in the same cycle
      if (|q_miss[3:0]) begin
         s_d.miss_hi = 1'b1;
      end
      if (|q_miss[7:4]) begin
         s_d.miss_lo = 1'b1;
      end

      // service state machine
      case (s_q.st)
         SRS_IDLE: begin
            if (grant) begin
               s_d.st = SRS_CELL;
               if (pick_hi[2]) begin
                  s_d.cur_q = {1'b0, pick_hi[1:0]};
                  s_d.rr_hi = pick_hi[1:0] + 2'b01;
               end else begin
                  s_d.cur_q = {1'b1, pick_lo[1:0]};
                  s_d.rr_lo = pick_lo[1:0] + 2'b01;
               end
            end
         end
         SRS_CELL: begin
            // keep sending until the last linked descriptor got its cell or the queue halts
            if (cell_done_in && (last_desc_in || halt_now)) begin
               s_d.st = SRS_IDLE;
            end
         end
         default: s_d.st = SRS_IDLE;
      endcase

      // circuit slots: release on completion, claim on accept
      for (int i = 0; i < `SRS_VC_SLOTS; i++) begin
         if (seg_done_in && s_q.vc_valid[i]
             && s_q.vc_id[i] == seg_done_vc_in) begin
            s_d.vc_valid[i] = 1'b0;
         end
      end
      if (link_accept_out) begin
         s_d.vc_valid[free_slot] = 1'b1;
         s_d.vc_id[free_slot]    = link_vc_in;
      end

      // control memory addresses, one cycle after their inputs
      s_d.q_addr = {s_q.qbase[11:0], queue_ptr_in};
      s_d.d_addr = {s_q.dbase[4:0], desc_num_in,
                    word_off_in, 1'b0};
      s_d.v_addr = srs_vc_addr(s_q.vc_base,
                               vc_from_cong_in ? cong_vc_index_in
                                               : desc_vc_index_in);
   end

   // =====================================================================
   // state register
   always_ff @(posedge clk_sys_in) begin
      if (sys_rst_in) begin
         s_q          <= '0;
         s_q.st       <= SRS_IDLE;
         s_q.vc_base  <= `SRS_WORD_RESET;
         s_q.pmatch   <= `SRS_WORD_RESET;
         s_q.qbase    <= `SRS_WORD_RESET;
         s_q.dbase    <= `SRS_WORD_RESET;
      end else begin
         s_q <= s_d;
      end
   end

   // =====================================================================
   // outputs
   assign reg_rdata_out              = s_q.rdata;
   assign cell_req_out               = (s_q.st == SRS_CELL);
   assign serve_active_out           = (s_q.st == SRS_CELL);
   assign serve_queue_out            = s_q.cur_q;
   assign queue_addr_out             = s_q.q_addr;
   assign desc_addr_out              = s_q.d_addr;
   assign vc_addr_out                = s_q.v_addr;
   assign high_bank_service_miss_out = s_q.miss_hi;
   assign low_bank_service_miss_out  = s_q.miss_lo;

endmodule

// ### src/srs_defines.svh
// register offsets, field positions, reset values and counts of the scheduler
`ifndef SRS_DEFINES_SVH
`define SRS_DEFINES_SVH

// ========================================================================
// register offsets (word index on the register port)
`define SRS_OFF_RQ_HI_BASE   4'h0
`define SRS_OFF_RQ_LO_BASE   4'h4
`define SRS_OFF_VC_BASE      4'h8
`define SRS_OFF_PAGE_MATCH   4'h9
`define SRS_OFF_QUEUE_BASE   4'hA
`define SRS_OFF_DESC_BASE    4'hB
`define SRS_OFF_STATUS       4'hC

// ========================================================================
// rate queue register fields
`define SRS_RQ_RELOAD_MSB    7
`define SRS_RQ_PRESC_LSB     8
`define SRS_RQ_PRESC_MSB     9
`define SRS_QUEUE_SERVICE_ON_BIT    10
`define SRS_RQ_PAUSE_BIT     11
`define SRS_RQ_USED_MASK     16'h0FFF

// ========================================================================
// status register fields
`define SRS_ST_HI_MISS_BIT   7
`define SRS_ST_LO_MISS_BIT   6

// ========================================================================
// page match register fields
`define SRS_PM_LOW_MSB       7
`define SRS_PM_HIGH_LSB      8
`define SRS_PM_MASK_LSB      12

// ========================================================================
// reset values and counts
`define SRS_WORD_RESET       16'h0000
`define SRS_CNT_RESET        8'h00
`define SRS_CNT_TOP          8'hFF
`define SRS_VC_SLOTS         8
`define SRS_VC_MIN_BASE      4
`define SRS_CM_AW            20

`endif

// ### src/srs_pkg.sv
// types shared by the rate queue scheduler files
package srs_pkg;

   // 16-bit register word
   typedef logic [15:0] srs_word_t;

   // control memory byte address
   typedef logic [19:0] srs_cm_addr_t;

   // scheduler states, gray along idle -> cell -> idle
   typedef enum logic [1:0] {
      SRS_IDLE = 2'b00,
      SRS_CELL = 2'b01
   } srs_state_t;

endpackage

// ### src/srs_rate_queue.sv
// one rate queue: prescaled reload counter and its service request
`timescale 1ns/100ps
`include "srs_defines.svh"

module srs_rate_queue (
   input  wire logic              clk_sys_in,
   input  wire logic              sys_rst_in,
   input  wire srs_pkg::srs_word_t cfg_in,
   input  wire logic [3:0]        tick_in,
   input  wire logic              permit_in,
   input  wire logic              ack_in,
   output logic                   req_out,
   output logic                   miss_out
);
   import srs_pkg::*;

   typedef struct packed {
      logic [7:0] cnt;
      logic       req;
      logic       miss;
   } srs_rq_state_t;

   srs_rq_state_t s_q;
   srs_rq_state_t s_d;

   logic       enable;
   logic       paused;
   logic       tick;
   logic [1:0] presc;

   // decoded configuration fields
   assign enable = cfg_in[`SRS_QUEUE_SERVICE_ON_BIT];
   assign presc  = cfg_in[`SRS_RQ_PRESC_MSB:`SRS_RQ_PRESC_LSB];
   assign paused = cfg_in[`SRS_RQ_PAUSE_BIT] & ~permit_in;
   assign tick   = tick_in[presc];

   // counting, reload and request bookkeeping
   always_comb begin
      s_d      = s_q;
      s_d.miss = 1'b0;
      if (ack_in) begin
         s_d.req = 1'b0;
      end
      if (!enable) begin
         s_d.req = 1'b0;
      end else if (tick) begin
         if (s_q.cnt == `SRS_CNT_TOP) begin
            s_d.cnt = cfg_in[`SRS_RQ_RELOAD_MSB:0];
            // overflow set wins over a same-cycle grant
            if (!paused) begin
               s_d.req  = 1'b1;
               s_d.miss = s_q.req & ~ack_in;
            end
         end else begin
            s_d.cnt = s_q.cnt + 8'h01;
         end
      end
   end

   always_ff @(posedge clk_sys_in) begin
      if (sys_rst_in) begin
         s_q <= '{cnt: `SRS_CNT_RESET, req: 1'b0, miss: 1'b0};
      end else begin
         s_q <= s_d;
      end
   end

   // a pending request is hidden while the link holds us off
   assign req_out  = s_q.req & ~paused;
   assign miss_out = s_q.miss;

endmodule

// ### verif/srs_props.sv
// checker of the rate queue scheduler ports
`timescale 1ns/100ps
module srs_props (
   input wire logic                  clk_sys_in,
   input wire logic                  sys_rst_in,
   input wire logic [3:0]            reg_addr_in,
   input wire srs_pkg::srs_word_t    reg_wdata_in,
   input wire logic                  reg_wr_in,
   input wire logic                  reg_rd_in,
   input wire srs_pkg::srs_word_t    reg_rdata_out,
   input wire logic                  cell_done_in,
   input wire logic                  last_desc_in,
   input wire logic                  cell_req_out,
   input wire logic [2:0]            serve_queue_out,
   input wire logic [7:0]            queue_ptr_in,
   input wire logic [9:0]            desc_num_in,
   input wire logic [3:0]            word_off_in,
   input wire srs_pkg::srs_cm_addr_t queue_addr_out,
   input wire srs_pkg::srs_cm_addr_t desc_addr_out,
   input wire logic                  pm_cycle_in,
   input wire logic [13:0]           pm_addr_in,
   input wire logic                  page_address_hit_out,
   input wire logic                  high_bank_service_miss_out
);
   import srs_pkg::*;
   srs_word_t pm_q;
   logic      hit_exp;
   default clocking @(posedge clk_sys_in); endclocking
   default disable iff (sys_rst_in);
   // =====
   // page match shadow
   always_ff @(posedge clk_sys_in) begin
      if (sys_rst_in) begin
         pm_q <= 16'h0000;
      end else if (reg_wr_in && reg_addr_in == 4'h9) begin
         pm_q <= reg_wdata_in;
      end
   end
   // upper bits with a clear mask bit drop out
   always_comb begin
      hit_exp = pm_cycle_in && pm_addr_in[9:2] == pm_q[7:0];
      for (int i = 0; i < 4; i++) begin
         if (pm_q[12+i] && pm_addr_in[10+i] != pm_q[8+i]) begin
            hit_exp = 1'b0;
         end
      end
   end
   // =====
   // register port
   property p_rd_idle;
      !reg_rd_in |=> reg_rdata_out == 16'h0000;
   endproperty
   a_rd_idle: assert property (p_rd_idle) else $error("rdata not idle");
   property p_rd_unused;
      reg_rd_in && reg_addr_in < 4'h8 |=> reg_rdata_out[15:12] == 4'h0;
   endproperty
   a_rd_unused: assert property (p_rd_unused)
      else $error("unused bits read");
   // =====
   // cell service
   property p_cell_hold;
      cell_req_out && !cell_done_in |=> cell_req_out;
   endproperty
   a_cell_hold: assert property (p_cell_hold)
      else $error("early end");
   property p_cell_end;
      cell_req_out && cell_done_in && last_desc_in |=> !cell_req_out;
   endproperty
   a_cell_end: assert property (p_cell_end)
      else $error("late end");
   property p_queue_hold;
      cell_req_out && $past(cell_req_out) |-> $stable(serve_queue_out);
   endproperty
   a_queue_hold: assert property (p_queue_hold)
      else $error("queue changed");
   // =====
   // addresses, page match and miss flag
   property p_qaddr;
      !$past(sys_rst_in) |-> queue_addr_out[7:0] == $past(queue_ptr_in);
   endproperty
   a_qaddr: assert property (p_qaddr)
      else $error("queue address");
   property p_daddr;
      !$past(sys_rst_in) |-> desc_addr_out[14:0] ==
         {$past(desc_num_in), $past(word_off_in), 1'b0};
   endproperty
   a_daddr: assert property (p_daddr)
      else $error("descriptor address");
   property p_hit_idle;
      !pm_cycle_in |-> !page_address_hit_out;
   endproperty
   a_hit_idle: assert property (p_hit_idle)
      else $error("idle page hit");
   property p_hit_eq;
      page_address_hit_out == hit_exp;
   endproperty
   a_hit_eq: assert property (p_hit_eq)
      else $error("page hit mismatch");
   property p_miss_keep;
      high_bank_service_miss_out &&
         !(reg_wr_in && reg_addr_in == 4'hC && reg_wdata_in[7])
         |=> high_bank_service_miss_out;
   endproperty
   a_miss_keep: assert property (p_miss_keep)
      else $error("miss flag lost");
   // =====
   // main scenarios
   c_serve: cover property (cell_req_out && cell_done_in && last_desc_in);
   c_hit: cover property (page_address_hit_out);
   c_miss: cover property ($rose(high_bank_service_miss_out));
endmodule

// ### verif/srs_cell_sink.sv
// far side model: cell interface answering each cell after a delay
`timescale 1ns/100ps
module srs_cell_sink (
   input  wire logic       clk_sys_in,
   input  wire logic       sys_rst_in,
   input  wire logic       cell_req_in,
   input  wire logic [3:0] ndesc_in,
   input  wire logic [7:0] delay_in,
   output logic            cell_done_out,
   output logic            last_desc_out
);
   logic [7:0] cyc_q;
   logic [3:0] n_q;
   // =====
   // one done pulse per cell; the last flag toggles when not qualified
   always_ff @(posedge clk_sys_in) begin
      if (sys_rst_in || !cell_req_in) begin
         cyc_q <= 8'h00;
         n_q <= 4'h0;
         cell_done_out <= 1'b0;
         last_desc_out <= !last_desc_out && !sys_rst_in;
      end else if (cyc_q == delay_in) begin
         cyc_q <= 8'h00;
         n_q <= n_q + 4'h1;
         cell_done_out <= 1'b1;
         last_desc_out <= n_q == ndesc_in - 4'h1;
      end else begin
         cyc_q <= cyc_q + 8'h01;
         cell_done_out <= 1'b0;
         last_desc_out <= !last_desc_out;
      end
   end
endmodule

// ### verif/test_srs_scheduler.sv
// self-checking testbench of the rate queue scheduler
`timescale 1ns/100ps
module test_srs_scheduler;
   import srs_pkg::*;
   logic         clk_sys_in, sys_rst_in, wr, rd, permit, lreq, sdone;
   logic         pmc, fcong, done, last, creq, act, acc, hit, mhi, mlo;
   logic [3:0]   addr, woff, ndesc;
   logic [7:0]   qptr, delay;
   logic [9:0]   dnum;
   logic [13:0]  pma;
   logic [2:0]   sq;
   srs_word_t    wdata, rdata, lvc, svc, dvc, cvc;
   srs_cm_addr_t qa, da, va, ve;
   int           fails, n_tests;
   srs_scheduler i_srs_scheduler (.clk_sys_in(clk_sys_in),
      .sys_rst_in(sys_rst_in), .reg_addr_in(addr), .reg_wdata_in(wdata),
      .reg_wr_in(wr), .reg_rd_in(rd), .reg_rdata_out(rdata),
      .transmit_permit_input_in(permit), .cell_done_in(done),
      .last_desc_in(last), .cell_req_out(creq), .serve_active_out(act),
      .serve_queue_out(sq), .link_req_in(lreq), .link_vc_in(lvc),
      .seg_done_in(sdone), .seg_done_vc_in(svc), .link_accept_out(acc),
      .queue_ptr_in(qptr), .desc_num_in(dnum), .word_off_in(woff),
      .desc_vc_index_in(dvc), .cong_vc_index_in(cvc),
      .vc_from_cong_in(fcong), .queue_addr_out(qa), .desc_addr_out(da),
      .vc_addr_out(va), .pm_cycle_in(pmc), .pm_addr_in(pma),
      .page_address_hit_out(hit), .high_bank_service_miss_out(mhi),
      .low_bank_service_miss_out(mlo));
   srs_cell_sink i_srs_cell_sink (.clk_sys_in(clk_sys_in),
      .sys_rst_in(sys_rst_in), .cell_req_in(creq), .ndesc_in(ndesc),
      .delay_in(delay), .cell_done_out(done), .last_desc_out(last));
   // =====
   // shared tasks
   task automatic test_done;
      if (fails == 0 && n_tests > 0) begin
         $display("bench passed");
      end else begin
         $display("bench failed");
      end
      $finish;
   endtask
   task automatic cmp(string what, logic [19:0] exp, logic [19:0] got);
      n_tests++;
      if (got !== exp) begin
         fails++;
         $display("BAD %s exp %h got %h", what, exp, got);
      end
   endtask
   task automatic wreg(logic [3:0] a, srs_word_t d);
      @(posedge clk_sys_in) {wr, addr, wdata} <= {1'b1, a, d};
      @(posedge clk_sys_in) wr <= 1'b0;
   endtask
   task automatic rreg(logic [3:0] a, srs_word_t e);
      @(posedge clk_sys_in) {rd, addr} <= {1'b1, a};
      @(posedge clk_sys_in) rd <= 1'b0;
      #1 cmp("reg_rdata", {4'h0, e}, {4'h0, rdata});
   endtask
   // grant wait
   task automatic wgrant(logic [2:0] q);
      int i;
      for (i = 0; i < 3000 && creq !== 1'b1; i++) @(posedge clk_sys_in) #1;
      if (i == 3000) begin
         fails++;
         test_done();
      end
      cmp("serve", {16'h0, 1'b1, q}, {16'h0, act, sq});
   endtask
   // service end
   task automatic wdrop(int n);
      int i, c;
      c = 0;
      for (i = 0; i < 3000 && creq === 1'b1; i++) begin
         @(posedge clk_sys_in) #1;
         c += int'(done === 1'b1);
      end
      if (i == 3000) begin
         fails++;
         test_done();
      end
      cmp("cells", 20'(n), 20'(c));
   endtask
   task automatic wnone(int n);
      repeat (n) @(posedge clk_sys_in) #1 cmp("idle", 20'h0, {19'h0, creq});
   endtask
   task automatic page(logic c, logic [13:0] a, logic e);
      @(posedge clk_sys_in) {pmc, pma} <= {c, a};
      #1 cmp("page_hit", {19'h0, e}, {19'h0, hit});
   endtask
   task automatic link(srs_word_t v, logic e);
      @(posedge clk_sys_in) {lreq, lvc} <= {1'b1, v};
      #1 cmp("link_accept", {19'h0, e}, {19'h0, acc});
      @(posedge clk_sys_in) lreq <= 1'b0;
   endtask
   // =====
   // scenarios
   task automatic t_regs;
      for (int a = 0; a < 13; a++) rreg(4'(a), 16'h0000);
      wreg(4'h0, 16'hFFFF);
      rreg(4'h0, 16'h0FFF);
      wreg(4'h0, 16'h0000);
      wreg(4'hE, 16'h1234);
      rreg(4'hE, 16'h0000);
   endtask
   task automatic t_addr;
      wreg(4'hA, 16'hABC5);
      wreg(4'hB, 16'h001F);
      @(posedge clk_sys_in) {qptr, dnum, woff, dvc, cvc} <=
         {8'h5A, 10'h2A5, 4'h9, 16'h9C3B, 16'h63C4};
      repeat (2) @(posedge clk_sys_in) #1;
      cmp("queue_addr", 20'hBC5_5A, qa);
      cmp("desc_addr", {5'h1F, 10'h2A5, 4'h9, 1'b0}, da);
      for (int c = 0; c < 8; c++) begin
         wreg(4'h8, 16'hA5A0 | 16'(c));
         @(posedge clk_sys_in) fcong <= c[0];
         repeat (2) @(posedge clk_sys_in) #1;
         ve = (20'h1 << (16 - c)) - 20'h1;
         ve = {16'hA5A0 | 16'(c), 4'h0} & ~ve | {4'h0, c[0] ? cvc : dvc} & ve;
         cmp("vc_addr", ve, va);
      end
   endtask
   task automatic t_page;
      wreg(4'h9, 16'h5A7C);
      page(1'b1, 14'h01F3, 1'b1);
      page(1'b1, 14'h29F0, 1'b1);
      page(1'b1, 14'h05F0, 1'b0);
      page(1'b1, 14'h11F0, 1'b0);
      page(1'b1, 14'h01F4, 1'b0);
      page(1'b0, 14'h01F0, 1'b0);
   endtask
   task automatic t_serve;
      {ndesc, delay, permit} <= {4'h3, 8'h04, 1'b0};
      wreg(4'h0, 16'h04F0);
      wgrant(3'h0);
      wdrop(3);
      wreg(4'h0, 16'h0000);
      wnone(300);
      {ndesc} <= 4'h8;
      wreg(4'h0, 16'h0CF0);
      wnone(300);
      permit <= 1'b1;
      wgrant(3'h0);
      permit <= 1'b0;
      wdrop(1);
      wreg(4'h0, 16'h0000);
   endtask
   task automatic t_prio;
      {ndesc, delay} <= {4'h1, 8'd150};
      wreg(4'h2, 16'h04F0);
      wreg(4'h3, 16'h04F0);
      wreg(4'h4, 16'h04F0);
      wgrant(3'h2);
      wdrop(1);
      wgrant(3'h3);
      cmp("miss_high", 20'h1, {19'h0, mhi});
      cmp("miss_low", 20'h1, {19'h0, mlo});
      for (int q = 1; q < 5; q++) wreg(4'(q), 16'h0000);
      wdrop(1);
      rreg(4'hC, 16'h00C0);
      wreg(4'hC, 16'h00C0);
      rreg(4'hC, 16'h0000);
   endtask
   task automatic t_link;
      link(16'd5, 1'b1);
      link(16'd5, 1'b0);
      @(posedge clk_sys_in) {sdone, svc} <= {1'b1, 16'd5};
      @(posedge clk_sys_in) sdone <= 1'b0;
      link(16'd5, 1'b1);
      for (int v = 10; v < 17; v++) link(16'(v), 1'b1);
      link(16'd17, 1'b0);
   endtask
   // =====
   // clock and main sequence
   initial begin
      clk_sys_in = 1'b0;
      forever #50 clk_sys_in = ~clk_sys_in;
   end
   initial begin
      {sys_rst_in, wr, rd, permit, lreq, sdone, pmc, fcong} = 8'h80;
      {addr, woff, ndesc, qptr, delay, dnum, pma} = '0;
      {wdata, lvc, svc, dvc, cvc} = '0;
      {fails, n_tests} = '0;
      repeat (12) @(posedge clk_sys_in);
      sys_rst_in <= 1'b0;
      t_regs();
      t_addr();
      t_page();
      t_serve();
      t_prio();
      t_link();
      test_done();
   end
endmodule
bind srs_scheduler srs_props i_srs_props (.*);
